// [logic/csa_regs.svh]
`ifndef CSA_REGS_SVH
`define CSA_REGS_SVH
// What this block does
// R1 - Flag minimum system regulation while held there
// R2 - Power management sets voltage/current limit flags
// R3 - Reduce charge current while input overloaded
// R4 - Supplement mode closes switch, depletion opens
// R5 - Off request opens switch, now or delayed
// R6 - Four events leave shipping mode
// R7 - Long button press pulses switch off
// R8 - Enable bit low suppresses pulse reset
// R9 - Power good needs all five conditions
// R10 - Alert is one 256 us low pulse
// R11 - Listed events each raise an alert
// R12 - Masked event classes raise no alert
// R13 - Fault latched until fault register read
// R14 - First read old content, second live
// R15 - Input overvoltage stops, code 01, alerts
// R16 - System overvoltage stops, enables discharge
// R17 - Source overvoltage clears enable, flags fault
// R18 - Source short runs repeated hiccup restart
// R19 - Safety timer expiry code 11, alert
// R20 - Button high restarts low-time measurement

// APB register byte offsets
`define CSA_OFS_CTRL 12'h000
`define CSA_OFS_STATUS 12'h004
`define CSA_OFS_FAULT 12'h008
`define CSA_OFS_MASK 12'h00c

// Control field positions
`define CSA_CTRL_OFF_REQ 0
`define CSA_CTRL_OFF_DLY 1
`define CSA_CTRL_RST_EN 2
`define CSA_CTRL_SRC_EN 3
`define CSA_CTRL_REG_RST 4
`define CSA_CTRL_RESET 32'h0000_0004

// Mask field positions
`define CSA_MASK_LIMIT 0
`define CSA_MASK_FAULT 1
`define CSA_MASK_STATUS 2

// Charge fault codes
`define CSA_CF_NONE 2'h0
`define CSA_CF_INOVP 2'h1
`define CSA_CF_THERM 2'h2
`define CSA_CF_TIMER 2'h3

// Timing, in microseconds / milliseconds, at 200 MHz
`define CSA_CLK_MHZ 200
`define CSA_ALERT_US 256
`define CSA_ALERT_CYC (`CSA_ALERT_US * `CSA_CLK_MHZ)
`define CSA_SHIP_DGL_MS 1
`define CSA_QON_RST_MS 8000
`define CSA_SW_RST_MS 250
`define CSA_OFF_DLY_MS 10000
`define CSA_HICCUP_MS 30
`define CSA_MS_CYC(ms) ((ms) * `CSA_CLK_MHZ * 1000)
`endif

// [logic/csa_pkg.sv]
package csa_pkg;
    // Analog comparator view of the power stage
    typedef struct packed {
        logic in_uvlo_ok;
        logic in_ovp;
        logic in_above_bat;
        logic in_not_poor;
        logic src_det_done;
        logic src_identified;
        logic chg_done;
        logic at_sys_min;
        logic in_cur_over;
        logic in_volt_under;
        logic sys_below_bat;
        logic bat_depleted;
        logic sys_ovp;
        logic src_out_ovp;
        logic src_short;
        logic wdog_exp;
        logic safety_exp;
        logic bat_ovp;
        logic ntc_fault;
        logic therm_sd;
    } csa_sense_t;

    // Power stage commands
    typedef struct packed {
        logic switching_en;
        logic reduce_chg;
        logic sys_discharge;
        logic source_run;
        logic battery_switch_on;
    } csa_drive_t;

    typedef enum logic [1:0] {
        CSA_SW_ON = 2'b00,
        CSA_SW_DLY = 2'b01,
        CSA_SW_SHIP = 2'b11,
        CSA_SW_RSTOFF = 2'b10
    } csa_sw_state_t;
endpackage

// [logic/csa_top.sv]
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "csa_regs.svh"
module csa_top #(
    parameter int SHIP_DGL_CYC = `CSA_MS_CYC(`CSA_SHIP_DGL_MS),
    parameter int QON_RST_CYC = `CSA_MS_CYC(`CSA_QON_RST_MS),
    parameter int SW_RST_CYC = `CSA_MS_CYC(`CSA_SW_RST_MS),
    parameter int OFF_DLY_CYC = `CSA_MS_CYC(`CSA_OFF_DLY_MS),
    parameter int HICCUP_CYC = `CSA_MS_CYC(`CSA_HICCUP_MS)
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Power stage
    input wire csa_pkg::csa_sense_t SENSE,
    output csa_pkg::csa_drive_t DRIVE,
    // Push button and alert
    input wire logic PUSH_BUTTON_N,
    output logic ALERT_N
);
    //==========================================================
    // Helpers
    //==========================================================
    // Saturating down count shared by the switch, hiccup and alert timers
    function automatic logic [31:0] dec(input logic [31:0] v);
        dec = (v == 32'h0) ? 32'h0 : v - 32'h1;
    endfunction

    //==========================================================
    // APB decode
    //==========================================================
    logic [31:0] ctrl_q, ctrl_d, mask_q;
    logic [31:0] fault_q, fault_d;
    logic fault_rd_q;
    logic [31:0] status_w, fault_live;
    logic [31:0] rdata_w;
    logic acc, wr, rd, rd_setup, hit_ctrl, hit_stat, hit_fault, hit_mask, mapped;

    // Zero wait state slave; unmapped access errors
    assign acc = PSEL & PENABLE;
    assign wr = acc & PWRITE;
    assign rd = acc & ~PWRITE;
    assign rd_setup = PSEL & ~PENABLE & ~PWRITE;
    assign hit_ctrl = PADDR == `CSA_OFS_CTRL;
    assign hit_stat = PADDR == `CSA_OFS_STATUS;
    assign hit_fault = PADDR == `CSA_OFS_FAULT;
    assign hit_mask = PADDR == `CSA_OFS_MASK;
    assign mapped = hit_ctrl | hit_stat | hit_fault | hit_mask;
    assign PREADY = 1'b1;
    assign PSLVERR = acc & ~mapped;
    assign rdata_w = hit_ctrl ? ctrl_q :
                     hit_stat ? status_w :
                     hit_fault ? fault_d : // Includes this cycle's events
                     hit_mask ? mask_q : 32'h0;

    // Loaded in setup so it already stands at the access edge
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            PRDATA <= 32'h0;
        end else if (rd_setup) begin
            PRDATA <= rdata_w;
        end
    end

    //==========================================================
    // Status flags
    //==========================================================
    logic power_good_flag, sys_min_reg_flag, input_volt_limit_flag, input_cur_limit_flag;
    logic dynamic_power_management;
    logic [1:0] charge_fault_code;
    logic source_mode_fault;

    assign dynamic_power_management = SENSE.in_cur_over | SENSE.in_volt_under;
    assign sys_min_reg_flag = SENSE.at_sys_min; // R1
    assign input_volt_limit_flag = dynamic_power_management & SENSE.in_volt_under; // R2
    assign input_cur_limit_flag = dynamic_power_management & SENSE.in_cur_over; // R2
    assign power_good_flag = SENSE.in_uvlo_ok & ~SENSE.in_ovp & SENSE.in_above_bat
                           & SENSE.in_not_poor & SENSE.src_det_done; // R9
    // Input overvoltage takes priority over timer expiry
    assign charge_fault_code = SENSE.in_ovp ? `CSA_CF_INOVP : // R15
                               SENSE.therm_sd ? `CSA_CF_THERM :
                               SENSE.safety_exp ? `CSA_CF_TIMER : // R19
                               `CSA_CF_NONE;
    assign source_mode_fault = SENSE.src_out_ovp & ctrl_q[`CSA_CTRL_SRC_EN]; // R17

    csa_pkg::csa_sw_state_t sw_q, sw_d;

    assign status_w = {24'h0, (sw_q == csa_pkg::CSA_SW_SHIP), DRIVE.battery_switch_on,
                       SENSE.chg_done, SENSE.src_identified, power_good_flag,
                       sys_min_reg_flag, input_volt_limit_flag, input_cur_limit_flag};
    assign fault_live = {24'h0, SENSE.wdog_exp, source_mode_fault, 1'b0, SENSE.bat_ovp,
                         SENSE.ntc_fault, SENSE.sys_ovp, charge_fault_code};

    //==========================================================
    // Fault register: latch until read
    //==========================================================
    // Holds while unread; the cycle after a read loads live state
    assign fault_d = fault_rd_q ? fault_live : // R13 R14
                     (fault_q | (fault_live & ~32'h3)) |
                     ((fault_q[1:0] == 2'h0) ? {30'h0, charge_fault_code} : 32'h0);

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            fault_q <= 32'h0;
            fault_rd_q <= 1'b0;
        end else begin
            fault_q <= fault_d; // R13
            fault_rd_q <= rd_setup & hit_fault; // R14
        end
    end

    //==========================================================
    // Control and mask registers
    //==========================================================
    logic src_clear, reg_rst, ship_leave;
    assign reg_rst = wr & hit_ctrl & PWDATA[`CSA_CTRL_REG_RST];
    // Hardware clear of source enable wins over a same-cycle write
    assign src_clear = source_mode_fault | SENSE.therm_sd;

    always_comb begin
        ctrl_d = ctrl_q;
        if (reg_rst) begin
            ctrl_d = `CSA_CTRL_RESET; // R6
        end else if (wr && hit_ctrl) begin
            ctrl_d = {27'h0, 1'b0, PWDATA[3:0]}; // R8
        end
        if (src_clear) begin
            ctrl_d[`CSA_CTRL_SRC_EN] = 1'b0; // R17
        end
        // A kept request would send the switch straight back to shipping
        if (ship_leave) begin
            ctrl_d[`CSA_CTRL_OFF_REQ] = 1'b0; // R6
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            ctrl_q <= `CSA_CTRL_RESET;
            mask_q <= 32'h0;
        end else begin
            ctrl_q <= ctrl_d;
            if (wr && hit_mask) begin
                mask_q <= {29'h0, PWDATA[2:0]};
            end
        end
    end

    //==========================================================
    // Push-button low time
    //==========================================================
    logic [31:0] low_cnt_q;
    logic btn_q, ship_exit, pulse_req, pulse_done_q;
    // Counts only while low; returning high restarts it
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            low_cnt_q <= 32'h0;
            btn_q <= 1'b1;
            pulse_done_q <= 1'b0;
        end else begin
            btn_q <= PUSH_BUTTON_N;
            if (PUSH_BUTTON_N) begin
                low_cnt_q <= 32'h0; // R20
                pulse_done_q <= 1'b0;
            end else if (low_cnt_q != 32'hffff_ffff) begin
                low_cnt_q <= low_cnt_q + 32'h1;
            end
            if (pulse_req) begin
                pulse_done_q <= 1'b1;
            end
        end
    end
    // High-to-low deglitched: low long enough after a fall
    assign ship_exit = ~btn_q & (low_cnt_q == SHIP_DGL_CYC); // R6
    // One reset per press, only when enabled, no input, switch on
    assign pulse_req = (low_cnt_q >= QON_RST_CYC) & ~pulse_done_q & ~power_good_flag
                     & ~ctrl_q[`CSA_CTRL_OFF_REQ] & ctrl_q[`CSA_CTRL_RST_EN]; // R7 R8

    //==========================================================
    // Battery switch state machine
    //==========================================================
    logic [31:0] sw_cnt_q, sw_cnt_d;
    logic sw_exit, depleted_q, depleted_d;

    assign sw_exit = power_good_flag | ~ctrl_q[`CSA_CTRL_OFF_REQ] | ship_exit; // R6
    // Hardware exits from shipping also drop the off request
    assign ship_leave = (sw_q == csa_pkg::CSA_SW_SHIP) & (power_good_flag | ship_exit); // R6

    always_comb begin
        sw_d = sw_q;
        sw_cnt_d = dec(sw_cnt_q);
        case (sw_q)
            csa_pkg::CSA_SW_ON: begin
                if (pulse_req) begin
                    sw_d = csa_pkg::CSA_SW_RSTOFF; // R7
                    sw_cnt_d = 32'(SW_RST_CYC - 1); // Zero is the last open cycle
                end else if (ctrl_q[`CSA_CTRL_OFF_REQ]) begin
                    sw_d = ctrl_q[`CSA_CTRL_OFF_DLY] ? csa_pkg::CSA_SW_DLY : csa_pkg::CSA_SW_SHIP; // R5
                    sw_cnt_d = 32'(OFF_DLY_CYC - 1);
                end
            end
            csa_pkg::CSA_SW_DLY: begin
                if (!ctrl_q[`CSA_CTRL_OFF_REQ]) begin
                    sw_d = csa_pkg::CSA_SW_ON;
                end else if (sw_cnt_q == 32'h0) begin
                    sw_d = csa_pkg::CSA_SW_SHIP; // R5
                end
            end
            csa_pkg::CSA_SW_SHIP: begin
                if (sw_exit) begin
                    sw_d = csa_pkg::CSA_SW_ON; // R6
                end
            end
            csa_pkg::CSA_SW_RSTOFF: begin
                if (sw_cnt_q == 32'h0) begin
                    sw_d = csa_pkg::CSA_SW_ON; // R7
                end
            end
            default: sw_d = csa_pkg::CSA_SW_ON;
        endcase
    end

    // Depletion latch: cleared only by an input source
    assign depleted_d = power_good_flag ? 1'b0 : (depleted_q | SENSE.bat_depleted); // R4

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            sw_q <= csa_pkg::CSA_SW_ON;
            sw_cnt_q <= 32'h0;
            depleted_q <= 1'b0;
        end else begin
            sw_q <= sw_d;
            sw_cnt_q <= sw_cnt_d;
            depleted_q <= depleted_d;
        end
    end

    //==========================================================
    // Source mode hiccup
    //==========================================================
    logic [31:0] hic_cnt_q;
    logic hic_off_q;
    // Retry period while short persists
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            hic_cnt_q <= 32'h0;
            hic_off_q <= 1'b0;
        end else if (SENSE.src_short && ctrl_q[`CSA_CTRL_SRC_EN]) begin
            if (hic_cnt_q == 32'h0) begin
                hic_cnt_q <= HICCUP_CYC; // R18
                hic_off_q <= ~hic_off_q;
            end else begin
                hic_cnt_q <= dec(hic_cnt_q);
            end
        end else begin
            hic_cnt_q <= 32'h0;
            hic_off_q <= 1'b0;
        end
    end

    //==========================================================
    // Power stage drive
    //==========================================================
    logic sw_closed;
    assign sw_closed = (sw_q == csa_pkg::CSA_SW_ON) | (sw_q == csa_pkg::CSA_SW_DLY);

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            DRIVE <= '0;
        end else begin
            DRIVE.switching_en <= ~SENSE.in_ovp & ~SENSE.sys_ovp & ~SENSE.therm_sd; // R15 R16
            DRIVE.reduce_chg <= dynamic_power_management; // R3
            DRIVE.sys_discharge <= SENSE.sys_ovp; // R16
            DRIVE.source_run <= ctrl_q[`CSA_CTRL_SRC_EN] & ~SENSE.src_out_ovp
                              & ~hic_off_q; // R17 R18
            // Already closed in the on and delayed states, so supplement needs no extra gate
            DRIVE.battery_switch_on <= sw_closed & ~depleted_d & ~SENSE.therm_sd; // R4
        end
    end

    //==========================================================
    // Alert pulse
    //==========================================================
    logic [4:0] ev_q, ev_now, ev_rise;
    logic [31:0] al_cnt_q;
    logic al_fire;
    // Classes: status, limit, fault
    assign ev_now = {SENSE.src_identified, power_good_flag | SENSE.chg_done,
                     ~power_good_flag, dynamic_power_management,
                     (charge_fault_code != `CSA_CF_NONE) | SENSE.wdog_exp | source_mode_fault
                     | SENSE.bat_ovp | SENSE.ntc_fault}; // R11
    assign ev_rise = ev_now & ~ev_q;
    assign al_fire = ((ev_rise[4] | ev_rise[3] | ev_rise[2]) & ~mask_q[`CSA_MASK_STATUS])
                   | (ev_rise[1] & ~mask_q[`CSA_MASK_LIMIT])
                   | (ev_rise[0] & ~mask_q[`CSA_MASK_FAULT]); // R12

    // New events during a pulse merge into it rather than queue
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            ev_q <= 5'h04;
            al_cnt_q <= 32'h0;
        end else begin
            ev_q <= ev_now;
            if (al_fire && al_cnt_q == 32'h0) begin
                al_cnt_q <= `CSA_ALERT_CYC; // R10
            end else begin
                al_cnt_q <= dec(al_cnt_q);
            end
        end
    end
    assign ALERT_N = (al_cnt_q == 32'h0); // R10
endmodule

// [verif/csa_top_checker.sv]
`timescale 1ns/1ps
`include "csa_regs.svh"
// ==========
// Port checks for the supervisor top
module csa_top_checker (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // Register bus
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    // Power stage and alert
    input wire csa_pkg::csa_sense_t SENSE,
    input wire csa_pkg::csa_drive_t DRIVE,
    input wire logic ALERT_N
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    logic [16:0] low_q;
    logic [16:0] low_d;
    wire rd_stat = PSEL && PENABLE && !PWRITE && PADDR == `CSA_OFS_STATUS;
    wire off_wr = PSEL && PENABLE && PWRITE && PADDR == `CSA_OFS_CTRL && PWDATA[1:0] == 2'b01;
    wire pg = SENSE.in_uvlo_ok && !SENSE.in_ovp && SENSE.in_above_bat && SENSE.in_not_poor && SENSE.src_det_done;
    // Low time of the alert, cleared while high
    assign low_d = ALERT_N ? 17'h0 : low_q + 17'h1;
    always_ff @(posedge CLOCK) low_q <= RST_N ? low_d : 17'h0;
    property p_alert_max; low_q <= `CSA_ALERT_CYC; endproperty
    a_alert_max: assert property (p_alert_max) else $error("alert pulse too long");
    property p_alert_len; $rose(ALERT_N) |-> low_q == `CSA_ALERT_CYC; endproperty
    a_alert_len: assert property (p_alert_len) else $error("alert pulse length wrong");
    property p_ovp_stop; SENSE.in_ovp |=> !DRIVE.switching_en; endproperty
    a_ovp_stop: assert property (p_ovp_stop) else $error("switching during input overvoltage");
    property p_sys_ovp; SENSE.sys_ovp |=> DRIVE.sys_discharge && !DRIVE.switching_en; endproperty
    a_sys_ovp: assert property (p_sys_ovp) else $error("system overvoltage not handled");
    property p_reduce; SENSE.in_cur_over || SENSE.in_volt_under |=> DRIVE.reduce_chg; endproperty
    a_reduce: assert property (p_reduce) else $error("charge current not reduced");
    property p_src_ovp; SENSE.src_out_ovp |=> !DRIVE.source_run; endproperty
    a_src_ovp: assert property (p_src_ovp) else $error("source mode kept on overvoltage");
    property p_off_now; off_wr |-> ##[1:3] !DRIVE.battery_switch_on; endproperty
    a_off_now: assert property (p_off_now) else $error("switch not opened at once");
    property p_stat; rd_stat |-> PRDATA[2:0] == $past({SENSE.at_sys_min, SENSE.in_volt_under, SENSE.in_cur_over}); endproperty
    a_stat: assert property (p_stat) else $error("regulation flags wrong");
    property p_pg; rd_stat |-> PRDATA[3] == $past(pg); endproperty
    a_pg: assert property (p_pg) else $error("power good flag wrong");
endmodule

bind csa_top csa_top_checker csa_top_checker_i (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .SENSE(SENSE), .DRIVE(DRIVE),
    .ALERT_N(ALERT_N));

// [verif/csa_host_model.sv]
`timescale 1ns/1ps
// ==========
// Host side: times each alert pulse it receives
module csa_host_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Alert from the block
    input wire logic alert_n,
    // Pulses seen and width of the last one
    output int pulse_cnt,
    output int last_width
);
    int run_q;
    // A pulse is reported only once the line is high again
    always @(posedge clock) begin
        if (!rst_n) begin
            run_q <= 0;
            pulse_cnt <= 0;
            last_width <= 0;
        end else if (alert_n === 1'b0) begin
            run_q <= run_q + 1;
        end else if (run_q != 0) begin
            pulse_cnt <= pulse_cnt + 1;
            last_width <= run_q;
            run_q <= 0;
        end
    end
endmodule

// [verif/csa_top_tb_top.sv]
`timescale 1ns/1ps
`include "csa_regs.svh"
module csa_top_tb_top;
    localparam int SW_RST = 10;
    logic clk;
    logic rst_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic err_q;
    logic [31:0] rd;
    logic button_n;
    logic alert_n;
    csa_pkg::csa_sense_t sense;
    csa_pkg::csa_drive_t drive;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int pulse_cnt;
    int last_width;
    // Short counts keep the run small
    csa_top #(.SHIP_DGL_CYC(4), .QON_RST_CYC(20), .SW_RST_CYC(SW_RST), .OFF_DLY_CYC(10), .HICCUP_CYC(8)) csa_top_i (
        .CLOCK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SENSE(sense), .DRIVE(drive),
        .PUSH_BUTTON_N(button_n), .ALERT_N(alert_n));
    csa_host_model csa_host_model_i (.clock(clk), .rst_n(rst_n), .alert_n(alert_n), .pulse_cnt(pulse_cnt),
        .last_width(last_width));
    // ==========
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_count++;
            final_report();
        end
    end
    // ==========
    // Shared tasks; drives are non-blocking at an edge, reads see settled values
    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        err_q = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so a following call never reassigns psel in this step
        @(posedge clk);
    endtask
    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        chk(name, exp, rd & m);
    endtask
    task automatic pg_set(input logic [3:0] v);
        sense.in_uvlo_ok <= v[0];
        sense.in_above_bat <= v[1];
        sense.in_not_poor <= v[2];
        sense.src_det_done <= v[3];
    endtask
    // Holds the button low n + 1 cycles and counts cycles with the switch open
    task automatic press(input string name, input int n, input int exp);
        int off;
        off = 0;
        button_n <= 1'b0;
        for (int i = 0; i < n + 30; i++) begin
            ticks(1);
            if (i == n) button_n <= 1'b1;
            if (drive.battery_switch_on !== 1'b1) off++;
        end
        chk(name, exp, off);
    endtask
    // ==========
    // Scenarios
    task automatic t_status();
        {sense.at_sys_min, sense.in_volt_under, sense.in_cur_over} <= 3'h7;
        ticks(3);
        chk("reduce_chg", 32'h1, drive.reduce_chg);
        rd_chk("status_lim", `CSA_OFS_STATUS, 32'h7, 32'h7);
        {sense.at_sys_min, sense.in_volt_under, sense.in_cur_over} <= 3'h0;
        ticks(3);
        rd_chk("status_idle", `CSA_OFS_STATUS, 32'h0, 32'h7);
    endtask
    task automatic t_pg();
        // One condition missing at a time, then all present
        for (int i = 0; i < 5; i++) begin
            pg_set(4'hf ^ (4'h1 << i));
            ticks(3);
            rd_chk("power_good", `CSA_OFS_STATUS, (i == 4) ? 32'h8 : 32'h0, 32'h8);
        end
        pg_set(4'h0);
    endtask
    task automatic t_fault();
        sense.in_ovp <= 1'b1;
        ticks(2);
        chk("switching_en", 32'h0, drive.switching_en);
        sense.in_ovp <= 1'b0;
        ticks(2);
        rd_chk("fault_old", `CSA_OFS_FAULT, 32'h1, 32'h3);
        rd_chk("fault_live", `CSA_OFS_FAULT, 32'h0, 32'h3);
        sense.safety_exp <= 1'b1;
        ticks(2);
        sense.safety_exp <= 1'b0;
        ticks(2);
        rd_chk("fault_timer", `CSA_OFS_FAULT, 32'h3, 32'h3);
        rd_chk("fault_clear", `CSA_OFS_FAULT, 32'h0, 32'h3);
        sense.sys_ovp <= 1'b1;
        ticks(2);
        chk("sys_discharge", 32'h1, drive.sys_discharge);
        sense.sys_ovp <= 1'b0;
        // Depletion opens the switch until an input source returns
        sense.bat_depleted <= 1'b1;
        ticks(2);
        sense.bat_depleted <= 1'b0;
        ticks(2);
        chk("depleted_off", 32'h0, drive.battery_switch_on);
        pg_set(4'hf);
        ticks(3);
        chk("depleted_exit", 32'h1, drive.battery_switch_on);
        pg_set(4'h0);
    endtask
    task automatic t_ship();
        apb(1'b1, `CSA_OFS_CTRL, 32'h5);
        ticks(3);
        rd_chk("shipping", `CSA_OFS_STATUS, 32'h80, 32'hc0);
        button_n <= 1'b0;
        ticks(6);
        button_n <= 1'b1;
        ticks(3);
        chk("exit_button", 32'h1, drive.battery_switch_on);
        // Plug-in, cleared request, register restore
        for (int k = 0; k < 3; k++) begin
            pg_set(4'h0);
            apb(1'b1, `CSA_OFS_CTRL, 32'h4);
            apb(1'b1, `CSA_OFS_CTRL, 32'h5);
            ticks(3);
            chk("switch_off", 32'h0, drive.battery_switch_on);
            if (k == 0) pg_set(4'hf);
            else apb(1'b1, `CSA_OFS_CTRL, (k == 1) ? 32'h4 : 32'h10);
            ticks(3);
            chk("switch_exit", 32'h1, drive.battery_switch_on);
        end
        rd_chk("ctrl_default", `CSA_OFS_CTRL, 32'h4, 32'h1f);
        apb(1'b1, `CSA_OFS_CTRL, 32'h7);
        ticks(5);
        chk("delay_on", 32'h1, drive.battery_switch_on);
        ticks(10);
        chk("delay_off", 32'h0, drive.battery_switch_on);
        apb(1'b1, `CSA_OFS_CTRL, 32'h4);
        ticks(3);
    endtask
    task automatic t_button();
        int off;
        off = 0;
        press("short_a", 12, 0);
        press("short_b", 12, 0);
        press("pulse_reset", 25, SW_RST);
        apb(1'b1, `CSA_OFS_CTRL, 32'h0);
        press("reset_off", 25, 0);
        apb(1'b1, `CSA_OFS_CTRL, 32'hc);
        ticks(2);
        chk("source_run", 32'h1, drive.source_run);
        // Short: off and on phases of 8 + 1 cycles, two off phases in 36
        sense.src_short <= 1'b1;
        for (int i = 0; i < 36; i++) begin
            ticks(1);
            if (drive.source_run !== 1'b1) off++;
        end
        chk("hiccup_off", 32'h12, off);
        sense.src_short <= 1'b0;
        sense.src_out_ovp <= 1'b1;
        ticks(2);
        sense.src_out_ovp <= 1'b0;
        rd_chk("src_en_clear", `CSA_OFS_CTRL, 32'h4, 32'hf);
        rd_chk("src_fault", `CSA_OFS_FAULT, 32'h40, 32'h40);
        apb(1'b0, 12'h010, 32'h0);
        chk("slverr", 32'h1, err_q);
    endtask
    task automatic t_alert();
        chk("masked_pulses", 32'h0, pulse_cnt);
        apb(1'b1, `CSA_OFS_MASK, 32'h0);
        ticks(4);
        sense.in_ovp <= 1'b1;
        ticks(2);
        sense.in_ovp <= 1'b0;
        while (pulse_cnt == 0) ticks(1);
        chk("alert_count", 32'h1, pulse_cnt);
        chk("alert_width", `CSA_ALERT_CYC, last_width);
    endtask
    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ==========
    // Main sequence; all classes masked until the alert check
    initial begin
        rst_n = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        sense = '0;
        button_n = 1'b1;
        ticks(12);
        rst_n <= 1'b1;
        ticks(1);
        apb(1'b1, `CSA_OFS_MASK, 32'h7);
        t_status();
        t_pg();
        t_fault();
        t_ship();
        t_button();
        t_alert();
        final_report();
    end
endmodule
